// File: sim/sbt_pin_source.sv
`timescale 1ns/10ps

// ==========
// External clock or gate source
module sbt_pin_source (
  output logic      pin,
  input  wire logic hclk
);
  // Idle low, as with a pull-down
  initial pin = 1'b0;

  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge hclk);
      pin <= 1'b1;
      repeat (w) @(posedge hclk);
      pin <= 1'b0;
      repeat (w - 1) @(posedge hclk);
    end
  endtask

  task automatic gate(input int w);
    @(posedge hclk);
    pin <= 1'b1;
    repeat (w) @(posedge hclk);
    pin <= 1'b0;
  endtask
endmodule // sbt_pin_source

// File: sim/sbt_timer_bench.sv
`timescale 1ns/10ps
`include "sbt_defines.svh"

module sbt_timer_bench;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pin;
  logic        idle_mode;
  logic        sleep_mode;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] held;
  int          num_errors;
  int          tests_run;
  logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
  logic [31:0] rstv [6] = '{0, 0, 32'h0000ffff, 0, 0, 0};
  int          ratio [4] = '{1, 8, 64, 256};

  sbt_timer i_sbt_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_clock_pin(pin), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .irq(irq)
  );

  sbt_pin_source i_sbt_pin_source (.pin(pin), .hclk(hclk));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ==========
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    // No cycle budget here: a stuck slave is caught by the watchdog
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic chk(input logic [31:0] got, exp, input string s);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, hi,
                         input string s);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("mismatch t=%0t %s got %0d", $time, s, got);
    end
  endtask

  task automatic run_chk(input logic [15:0] c, input int cyc, lo, hi);
    wr(`SBT_CTRL_OFS, {16'h0, c});
    wr(`SBT_COUNT_OFS, 32'h0);
    repeat (cyc) @(posedge hclk);
    rdr(`SBT_COUNT_OFS);
    chk_rng(rd, lo, hi, "count");
  endtask

  task automatic ext_chk(input logic [15:0] c);
    wr(`SBT_CTRL_OFS, {16'h0, c});
    wr(`SBT_COUNT_OFS, 32'h0);
    i_sbt_pin_source.pulses(5, 3);
    repeat (8) @(posedge hclk);
    rdr(`SBT_COUNT_OFS);
    chk(rd, 32'h5, "ext count");
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run is near 4500 cycles
  initial begin
    #400us;
    num_errors++;
    report_and_stop;
  end

  // ==========
  // Tests
  initial begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    idle_mode = 1'b0;
    sleep_mode = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      rdr(ofs[i]);
      chk(rd, rstv[i], "reset value");
      chk({31'h0, hresp}, 32'h0, "response okay");
    end
    wr(`SBT_CTRL_OFS, 32'hffffffff);
    rdr(`SBT_CTRL_OFS);
    chk(rd, 32'h0000a076, "control");
    wr(8'h20, 32'h5a5a5a5a);
    rdr(8'h20);
    chk(rd, 32'h0, "unmapped");
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      run_chk(16'h8000 | (16'(p) << 4), 1024,
              1024 / ratio[p] - 1, 1024 / ratio[p] + 4);
    end
    $display("test prescale done");
    wr(`SBT_CTRL_OFS, 32'h0);
    rdr(`SBT_COUNT_OFS);
    held = rd;
    repeat (20) @(posedge hclk);
    rdr(`SBT_COUNT_OFS);
    chk(rd, held, "stopped");
    idle_mode <= 1'b1;
    run_chk(16'ha000, 50, 0, 0);
    run_chk(16'h8000, 50, 49, 54);
    idle_mode <= 1'b0;
    $display("test idle done");
    sleep_mode <= 1'b1;
    run_chk(16'h8000, 50, 0, 0);
    ext_chk(16'h8042);
    sleep_mode <= 1'b0;
    ext_chk(16'h8006);
    $display("test external done");
    wr(`SBT_STATUS_OFS, 32'h3);
    wr(`SBT_CTRL_OFS, 32'h8040);
    wr(`SBT_COUNT_OFS, 32'h0);
    i_sbt_pin_source.gate(20);
    repeat (8) @(posedge hclk);
    rdr(`SBT_COUNT_OFS);
    chk_rng(rd, 18, 22, "gated count");
    rdr(`SBT_STATUS_OFS);
    chk(rd, 32'h2, "gate status");
    $display("test gate done");
    wr(`SBT_CTRL_OFS, 32'h0);
    wr(`SBT_STATUS_OFS, 32'h3);
    wr(`SBT_MASK_OFS, 32'h1);
    wr(`SBT_PERIOD_OFS, 32'h2);
    // Count left over from the gate test lies above the period
    wr(`SBT_COUNT_OFS, 32'h0);
    wr(`SBT_CTRL_OFS, 32'h8000);
    repeat (10) @(posedge hclk);
    rdr(`SBT_COUNT_OFS);
    chk_rng(rd, 0, 2, "wrap");
    rdr(`SBT_STATUS_OFS);
    chk(rd, 32'h1, "match status");
    chk({31'h0, irq}, 32'h1, "irq set");
    wr(`SBT_MASK_OFS, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(`SBT_CTRL_OFS, 32'h0);
    wr(`SBT_MASK_OFS, 32'h1);
    wr(`SBT_STATUS_OFS, 32'h1);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rdr(`SBT_STATUS_OFS);
    chk(rd, 32'h0, "status cleared");
    $display("test interrupt done");
    report_and_stop;
  end
endmodule // sbt_timer_bench

// File: verilog/sbt_defines.svh
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define SBT_CTRL_OFS    8'h00
`define SBT_COUNT_OFS   8'h04
`define SBT_PERIOD_OFS  8'h08
`define SBT_STATUS_OFS  8'h0c
`define SBT_MASK_OFS    8'h10

// ==========================================================
// Control field positions
`define SBT_RUN_BIT     15
`define SBT_IDLE_BIT    13
`define SBT_GATE_BIT    6
`define SBT_PS_HI       5
`define SBT_PS_LO       4
`define SBT_SYNC_BIT    2
`define SBT_SRC_BIT     1
`define SBT_CTRL_WMASK  16'ha076

// ==========================================================
// Status and mask bits
`define SBT_EV_MATCH    0
`define SBT_EV_GATE     1

// ==========================================================
// Reset values
`define SBT_CTRL_RST    16'h0000
`define SBT_COUNT_RST   16'h0000
`define SBT_PERIOD_RST  16'hffff

// ==========================================================
// Prescaler terminal counts (ratio minus one)
`define SBT_PS_DIV1     8'h00
`define SBT_PS_DIV8     8'h07
`define SBT_PS_DIV64    8'h3f
`define SBT_PS_DIV256   8'hff

`endif

// File: verilog/sbt_pkg.sv
package sbt_pkg;

  // ==========================================================
  // Counting modes
  typedef enum logic [1:0] {
    SBT_TIMER = 2'b00,
    SBT_GATED = 2'b01,
    SBT_SYNC  = 2'b10,
    SBT_ASYNC = 2'b11
  } sbt_mode_e;

endpackage

// File: verilog/sbt_prescaler.sv
`timescale 1ns/10ps

module sbt_prescaler #(
  parameter int PS_W = 8
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            clear,
  input  wire logic            tick_in,
  input  wire logic [PS_W-1:0] term,
  output logic                 tick_out
);

  logic [PS_W-1:0] cnt_reg;

  assign tick_out = tick_in && (cnt_reg == term);

  // ==========================================================
  // Divider counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
    end else if (tick_in) begin
      cnt_reg <= (cnt_reg == term) ? '0 : cnt_reg + 1'b1;
    end
  end

endmodule // sbt_prescaler

// File: verilog/sbt_timer.sv
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`include "sbt_defines.svh"

module sbt_timer
  import sbt_pkg::*;
#(
  parameter int PS_W = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        external_clock_pin,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  output logic             irq
);

  // ==========================================================
  // Elaboration check
  generate
    if (PS_W < 8) begin : g_bad_width
      $error("PS_W must be at least 8");
    end
  endgenerate

  logic [15:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] period_reg;
  logic [1:0]  status_reg;
  logic [1:0]  mask_reg;
  logic        irq_reg;
  logic [31:0] hrdata_reg;
  logic        hready_reg;
  logic        hresp_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        rd_pend_reg;
  logic [7:0]  rd_addr_reg;
  logic        ext_s1_reg;
  logic        ext_s2_reg;
  logic        ext_s3_reg;
  logic        rise_d_reg;

  logic            req;
  logic            ctrl_wr;
  logic            count_wr;
  logic            period_wr;
  logic            status_wr;
  logic            mask_wr;
  logic [31:0]     rd_mux;
  logic            run;
  logic            idle_stop;
  sbt_mode_e       mode;
  logic            halted;
  logic            run_ok;
  logic            rise;
  logic            fall;
  logic            raw_tick;
  logic            tick;
  logic [PS_W-1:0] term;
  logic            match_ev;
  logic            gate_ev;
  logic [1:0]      ev_set;

  // ==========================================================
  // Bus decode
  assign req = hsel && htrans[1] && hready;
  assign ctrl_wr   = wr_pend_reg && (wr_addr_reg == `SBT_CTRL_OFS);
  assign count_wr  = wr_pend_reg && (wr_addr_reg == `SBT_COUNT_OFS);
  assign period_wr = wr_pend_reg && (wr_addr_reg == `SBT_PERIOD_OFS);
  assign status_wr = wr_pend_reg && (wr_addr_reg == `SBT_STATUS_OFS);
  assign mask_wr   = wr_pend_reg && (wr_addr_reg == `SBT_MASK_OFS);

  always_comb begin
    if (rd_addr_reg == `SBT_CTRL_OFS) begin
      rd_mux = {16'h0000, ctrl_reg};
    end else if (rd_addr_reg == `SBT_COUNT_OFS) begin
      rd_mux = {16'h0000, count_reg};
    end else if (rd_addr_reg == `SBT_PERIOD_OFS) begin
      rd_mux = {16'h0000, period_reg};
    end else if (rd_addr_reg == `SBT_STATUS_OFS) begin
      rd_mux = {30'h0, status_reg};
    end else if (rd_addr_reg == `SBT_MASK_OFS) begin
      rd_mux = {30'h0, mask_reg};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // ==========================================================
  // Bus handshake
  // Reads take one wait state so a write just ahead has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_reg  <= 1'b1;
      hresp_reg   <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      hready_reg  <= !(req && !hwrite);
      hresp_reg   <= 1'b0;
      rd_pend_reg <= req && !hwrite;
      wr_pend_reg <= req && hwrite;
      if (req) begin
        rd_addr_reg <= haddr[7:0];
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  // ==========================================================
  // Control, period and mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `SBT_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= hwdata[15:0] & `SBT_CTRL_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_reg <= `SBT_PERIOD_RST;
    end else if (period_wr) begin
      period_reg <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= 2'b00;
    end else if (mask_wr) begin
      mask_reg <= hwdata[1:0];
    end
  end

  // ==========================================================
  // Mode selection
  assign run       = ctrl_reg[`SBT_RUN_BIT];
  assign idle_stop = ctrl_reg[`SBT_IDLE_BIT];

  always_comb begin
    if (ctrl_reg[`SBT_SRC_BIT]) begin
      mode = ctrl_reg[`SBT_SYNC_BIT] ? SBT_SYNC : SBT_ASYNC;
    end else begin
      mode = ctrl_reg[`SBT_GATE_BIT] ? SBT_GATED : SBT_TIMER;
    end
  end

  // low-power halting
  // Only the async counter survives sleep: it needs no internal clock
  assign halted = (idle_mode && idle_stop)
               || (sleep_mode && (mode != SBT_ASYNC));
  assign run_ok = run && !halted;

  // ==========================================================
  // Pin synchroniser and edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      rise_d_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_clock_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      rise_d_reg <= rise;
    end
  end

  assign rise = ext_s2_reg && !ext_s3_reg;
  assign fall = !ext_s2_reg && ext_s3_reg;

  always_comb begin
    case (mode)
      SBT_TIMER: raw_tick = 1'b1;
      SBT_GATED: raw_tick = ext_s2_reg;
      // extra stage aligns to the internal clock
      SBT_SYNC:  raw_tick = rise_d_reg;
      SBT_ASYNC: raw_tick = rise;
      default:   raw_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Prescaler
  always_comb begin
    case (ctrl_reg[`SBT_PS_HI:`SBT_PS_LO])
      2'b00:   term = PS_W'(`SBT_PS_DIV1);
      2'b01:   term = PS_W'(`SBT_PS_DIV8);
      2'b10:   term = PS_W'(`SBT_PS_DIV64);
      default: term = PS_W'(`SBT_PS_DIV256);
    endcase
  end

  sbt_prescaler #(
    .PS_W     (PS_W)
  ) u_prescaler (
    .clk      (hclk),
    .rstn     (hresetn),
    .clear    (!run || ctrl_wr),
    .tick_in  (raw_tick && run_ok),
    .term     (term),
    .tick_out (tick)
  );

  // ==========================================================
  // Counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= `SBT_COUNT_RST;
    end else if (count_wr) begin
      count_reg <= hwdata[15:0];
    end else if (tick) begin
      if (count_reg == period_reg) begin
        count_reg <= 16'h0000;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Events and interrupt
  // match and gate-fall events
  assign match_ev = tick && (count_reg == period_reg);
  assign gate_ev  = (mode == SBT_GATED) && fall && run_ok;
  assign ev_set   = {gate_ev, match_ev};

  // A new event beats a same-cycle write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= 2'b00;
    end else begin
      status_reg <= (status_reg & ~(status_wr ? hwdata[1:0] : 2'b00))
                  | ev_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign hreadyout = hready_reg;
  assign hresp     = hresp_reg;
  assign hrdata    = hrdata_reg;
  assign irq       = irq_reg;

  // ==========================================================
  // Assertions
  property p_ctrl_zero;
    @(posedge hclk) disable iff (!hresetn)
    (ctrl_reg & ~`SBT_CTRL_WMASK) == 16'h0000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("unimplemented control bit set");

  property p_stop_holds;
    @(posedge hclk) disable iff (!hresetn)
    (!run && !count_wr) |=> $stable(count_reg);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("count moved while stopped");

  property p_idle_halt;
    @(posedge hclk) disable iff (!hresetn)
    (idle_mode && idle_stop && !count_wr) |=> $stable(count_reg);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("count moved in idle with stop set");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (tick && count_reg == period_reg && !count_wr)
      |=> count_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap after match");

  property p_match_flag;
    @(posedge hclk) disable iff (!hresetn)
    match_ev |=> status_reg[`SBT_EV_MATCH] ##1 (irq_reg || !$past(mask_reg[0]));
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match flag or interrupt missing");

  property p_gate_fall;
    @(posedge hclk) disable iff (!hresetn)
    (run_ok && mode == SBT_GATED && ext_s3_reg && !ext_s2_reg)
      |=> status_reg[`SBT_EV_GATE];
  endproperty
  a_gate_fall: assert property (p_gate_fall)
    else $error("gate fall flag missing");

  property p_gate_low;
    @(posedge hclk) disable iff (!hresetn)
    (mode == SBT_GATED && !ext_s2_reg && !count_wr)
      |=> $stable(count_reg);
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("gated count moved with gate low");

  property p_timer_inc;
    @(posedge hclk) disable iff (!hresetn)
    (run_ok && mode == SBT_TIMER && ctrl_reg[5:4] == 2'b00
      && count_reg != period_reg && !count_wr && !ctrl_wr)
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_timer_inc: assert property (p_timer_inc)
    else $error("internal timer did not count each cycle");

  property p_div8;
    @(posedge hclk) disable iff (!hresetn)
    (tick && mode == SBT_TIMER && ctrl_reg[5:4] == 2'b01
      && run_ok && !ctrl_wr && !idle_mode && !sleep_mode)
      |=> !tick [*7];
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by 8 ticked early");

  property p_sleep_async;
    @(posedge hclk) disable iff (!hresetn)
    (sleep_mode && !idle_mode && run && mode == SBT_ASYNC)
      |-> run_ok;
  endproperty
  a_sleep_async: assert property (p_sleep_async)
    else $error("async counter halted in sleep");

endmodule // sbt_timer
